// *** bcc_defines.vh ***
// constants for the branch / call / clear execution block
`ifndef BCC_DEFINES_VH
`define BCC_DEFINES_VH
// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define BCC_OP_BR_ZERO_HI   8'hE0
`define BCC_OP_BR_OVF_HI    8'hE4
`define BCC_OP_CALL_HI7     7'h76
`define BCC_OP_CALL2_HI4    4'hF
`define BCC_OP_CLR_FILE_HI7 7'h35
`define BCC_OP_WD_CLEAR     16'h0004
`define BCC_IR_IDLE         16'hFFFF
// ----------------------------------------
// field positions inside the instruction words
// ----------------------------------------
`define BCC_F_OPHI8       15:8
`define BCC_F_OPHI7       15:9
`define BCC_F_OPHI4       15:12
`define BCC_F_LOWBYTE     7:0
`define BCC_F_SEL         8
`define BCC_F_SIGN        7
`define BCC_F_KHIGH       11:0
`define BCC_SEXT_W        12
// ----------------------------------------
// widths, phases and reset values
// ----------------------------------------
`define BCC_PC_W          21
`define BCC_PH_W          4
`define BCC_PH_Q1         4'h1
`define BCC_PH_Q2         4'h2
`define BCC_PH_Q3         4'h4
`define BCC_PH_Q4         4'h8
`define BCC_PC_RST        21'h000000
`define BCC_PC_STEP       21'h000002
`define BCC_CALL_RET      21'h000004
`define BCC_BYTE_ZERO     8'h00
`define BCC_ZERO_BIT      2
`define BCC_OV_BIT        3
`endif

// *** bcc_phase_gen.v ***
// four-phase instruction cycle generator
`include "bcc_defines.vh"
module bcc_phase_gen
(
  input  wire                  core_clk_in,
  input  wire                  sys_rst_in,
  output reg  [`BCC_PH_W-1:0]  phase_out
);
  // ----------------------------------------
  // one-hot rotating phase
  // ----------------------------------------
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      phase_out <= `BCC_PH_Q1;
    else
      phase_out <= {phase_out[`BCC_PH_W-2:0], phase_out[`BCC_PH_W-1]};
  end
endmodule

// *** bcc_exec.v ***
// execution of relative branches, two-word call, register clear and watchdog clear
`include "bcc_defines.vh"
module bcc_exec
(
  input  wire                  core_clk_in,
  input  wire                  sys_rst_in,
  input  wire [15:0]           instr_word_in,
  input  wire [15:0]           second_word_in,
  input  wire                  instr_valid_in,
  input  wire [`BCC_PC_W-1:0]  pc_incr_in,
  input  wire [7:0]            status_in,
  input  wire [7:0]            working_in,
  input  wire [7:0]            bank_select_register_in,
  output reg  [`BCC_PC_W-1:0]  pc_out,
  output reg                   pc_write_out,
  output reg                   push_out,
  output reg  [`BCC_PC_W-1:0]  top_of_return_stack_out,
  output reg  [7:0]            working_shadow_out,
  output reg  [7:0]            status_shadow_out,
  output reg  [7:0]            bank_select_shadow_out,
  output reg                   clr_write_out,
  output reg  [7:0]            clr_addr_out,
  output reg                   clr_bank_out,
  output reg  [7:0]            clr_data_out,
  output reg                   zero_set_out,
  output reg                   watchdog_counter_clr_out,
  output reg                   postscaler_clr_out,
  output reg                   timeout_flag_n_set_out,
  output reg                   powerdown_flag_n_set_out,
  output reg                   busy_out,
  output reg  [`BCC_PH_W-1:0]  phase_out
);
  // ----------------------------------------
  // state machine codes
  // ----------------------------------------
  localparam ST_EXEC = 2'b01;
  localparam ST_NOP  = 2'b10;

  wire [`BCC_PH_W-1:0] phase;
  reg  [1:0]           state;
  reg  [1:0]           next_state;
  reg  [15:0]          ir;
  reg  [7:0]           k_low;
  reg                  save_sel;

  bcc_phase_gen u_phase
  (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .phase_out   (phase)
  );

  // ----------------------------------------
  // fields of the latched and second words
  // ----------------------------------------
  // the second call word is read live, so it must stand from phase two to phase four
  wire [7:0]           op_hi8    = ir[`BCC_F_OPHI8];
  wire [6:0]           op_hi7    = ir[`BCC_F_OPHI7];
  wire [3:0]           w2_hi4    = second_word_in[`BCC_F_OPHI4];
  wire [7:0]           lit_low   = ir[`BCC_F_LOWBYTE];
  wire                 sel_bit   = ir[`BCC_F_SEL];
  wire [11:0]          k_high    = second_word_in[`BCC_F_KHIGH];
  wire                 zero_flag = status_in[`BCC_ZERO_BIT];
  wire                 ovf_flag  = status_in[`BCC_OV_BIT];
  wire [`BCC_PC_W-1:0] br_offset = {{`BCC_SEXT_W{lit_low[`BCC_F_SIGN]}}, lit_low, 1'b0};

  // ----------------------------------------
  // decode of the latched word, with the call also checking the live second word
  // ----------------------------------------
  wire is_br_zero  = (op_hi8 == `BCC_OP_BR_ZERO_HI);
  wire is_br_ovf   = (op_hi8 == `BCC_OP_BR_OVF_HI);
  wire is_call     = (op_hi7 == `BCC_OP_CALL_HI7) && (w2_hi4 == `BCC_OP_CALL2_HI4);
  wire is_clr_file = (op_hi7 == `BCC_OP_CLR_FILE_HI7);
  wire is_wdclr    = (ir == `BCC_OP_WD_CLEAR);
  wire br_taken    = (is_br_zero && zero_flag)
                     || (is_br_ovf && ovf_flag);
  // pc_incr_in already points past the branch word
  wire [`BCC_PC_W-1:0] br_target = pc_incr_in + br_offset;
  wire [`BCC_PC_W-1:0] ret_addr  = pc_incr_in - `BCC_PC_STEP
                  + `BCC_CALL_RET;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // a taken branch or call throws away the word fetched behind it, hence the
  // dead cycle that follows; no word is sampled during those four clocks
  always @*
  begin
    next_state = state;
    case (state)
      ST_EXEC:
        if (phase == `BCC_PH_Q4 && (br_taken || is_call))
          next_state = ST_NOP;
      ST_NOP:
        if (phase == `BCC_PH_Q4)
          next_state = ST_EXEC;
      default:
        next_state = ST_EXEC;
    endcase
  end

  // ----------------------------------------
  // per-phase actions; strobe outputs other than busy_out are one-cycle pulses
  // ----------------------------------------
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      state                    <= ST_EXEC;
      ir                       <= `BCC_IR_IDLE;
      k_low                    <= `BCC_BYTE_ZERO;
      save_sel                 <= 1'b0;
      pc_out                   <= `BCC_PC_RST;
      pc_write_out             <= 1'b0;
      push_out                 <= 1'b0;
      top_of_return_stack_out  <= `BCC_PC_RST;
      working_shadow_out       <= `BCC_BYTE_ZERO;
      status_shadow_out        <= `BCC_BYTE_ZERO;
      bank_select_shadow_out   <= `BCC_BYTE_ZERO;
      clr_write_out            <= 1'b0;
      clr_addr_out             <= `BCC_BYTE_ZERO;
      clr_bank_out             <= 1'b0;
      clr_data_out             <= `BCC_BYTE_ZERO;
      zero_set_out             <= 1'b0;
      watchdog_counter_clr_out <= 1'b0;
      postscaler_clr_out       <= 1'b0;
      timeout_flag_n_set_out   <= 1'b0;
      powerdown_flag_n_set_out <= 1'b0;
      busy_out                 <= 1'b0;
      phase_out                <= `BCC_PH_Q1;
    end
    else
    begin
      state                    <= next_state;
      phase_out                <= phase;
      pc_write_out             <= 1'b0;
      push_out                 <= 1'b0;
      clr_write_out            <= 1'b0;
      zero_set_out             <= 1'b0;
      watchdog_counter_clr_out <= 1'b0;
      postscaler_clr_out       <= 1'b0;
      timeout_flag_n_set_out   <= 1'b0;
      powerdown_flag_n_set_out <= 1'b0;
      busy_out                 <= (state == ST_NOP);
      // invalid word loads the idle word, which decodes as nothing in the exec cycle
      if (state == ST_EXEC && phase == `BCC_PH_Q1)
        ir <= instr_valid_in ? instr_word_in : `BCC_IR_IDLE;
      if (state == ST_EXEC)
      begin
        // ----------------------------------------
        // call sequence, phases two and three
        // ----------------------------------------
        // the save bit is latched with the low byte so phase three sees a settled copy
        if (phase == `BCC_PH_Q2 && is_call)
        begin
          k_low    <= lit_low;
          save_sel <= sel_bit;
        end
        if (phase == `BCC_PH_Q3 && is_call)
        begin
          push_out                <= 1'b1;
          top_of_return_stack_out <= ret_addr;
          if (save_sel)
          begin
            working_shadow_out     <= working_in;
            status_shadow_out      <= status_in;
            bank_select_shadow_out <= bank_select_register_in;
          end
        end
        // ----------------------------------------
        // phase-four writes
        // ----------------------------------------
        // strobes leave one clock after this edge; the pc, file and watchdog
        // owners outside act on them, so each strobe lasts exactly one clock
        if (phase == `BCC_PH_Q4)
        begin
          if (is_call)
          begin
            pc_write_out <= 1'b1;
            pc_out       <= {k_high, k_low, 1'b0};
          end
          else if (br_taken)
          begin
            pc_write_out <= 1'b1;
            pc_out       <= br_target;
          end
          else
            pc_out <= pc_incr_in;
          if (is_clr_file)
          begin
            clr_write_out <= 1'b1;
            clr_addr_out  <= lit_low;
            clr_bank_out  <= sel_bit;
            clr_data_out  <= `BCC_BYTE_ZERO;
            zero_set_out  <= 1'b1;
          end
          if (is_wdclr)
          begin
            watchdog_counter_clr_out <= 1'b1;
            postscaler_clr_out       <= 1'b1;
            timeout_flag_n_set_out   <= 1'b1;
            powerdown_flag_n_set_out <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// *** bcc_exec_chk.sv ***
// port-level assertions for the branch, call and clear execution block
`include "bcc_defines.vh"
module bcc_exec_chk
(
  input wire logic                 core_clk_in,
  input wire logic                 sys_rst_in,
  input wire logic [15:0]          second_word_in,
  input wire logic [`BCC_PC_W-1:0] pc_incr_in,
  input wire logic [`BCC_PC_W-1:0] pc_out,
  input wire logic                 pc_write_out,
  input wire logic                 push_out,
  input wire logic [`BCC_PC_W-1:0] top_of_return_stack_out,
  input wire logic [7:0]           working_shadow_out,
  input wire logic                 clr_write_out,
  input wire logic [7:0]           clr_data_out,
  input wire logic                 zero_set_out,
  input wire logic                 watchdog_counter_clr_out,
  input wire logic                 postscaler_clr_out,
  input wire logic                 timeout_flag_n_set_out,
  input wire logic                 powerdown_flag_n_set_out,
  input wire logic                 busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_pcw_pulse: assert property (pc_write_out |=> !pc_write_out)
    else $error("pc write wider than one clock");
  a_push_then_write: assert property (push_out |=> pc_write_out && !push_out)
    else $error("call push not followed by pc write");
  a_return_addr: assert property (push_out |-> top_of_return_stack_out == pc_incr_in + 21'h000002)
    else $error("return address wrong");
  a_call_target: assert property (push_out |=> pc_out[20:9] == $past(second_word_in[11:0]) && !pc_out[0])
    else $error("call target wrong");
  a_clear_zero: assert property (clr_write_out |-> clr_data_out == 8'h00 && zero_set_out)
    else $error("clear without zero data or zero flag");
  a_watchdog_group: assert property (watchdog_counter_clr_out |-> postscaler_clr_out && timeout_flag_n_set_out
    && powerdown_flag_n_set_out)
    else $error("watchdog clear strobes split");
  a_busy_length: assert property ($rose(busy_out) |-> busy_out [*4] ##1 !busy_out)
    else $error("idle cycle not four clocks");
  a_shadow_hold: assert property (!$stable(working_shadow_out) |-> push_out)
    else $error("shadow changed outside a call");
endmodule
bind bcc_exec bcc_exec_chk i_bcc_exec_chk (.core_clk_in, .sys_rst_in, .second_word_in, .pc_incr_in, .pc_out,
  .pc_write_out, .push_out, .top_of_return_stack_out, .working_shadow_out, .clr_write_out, .clr_data_out,
  .zero_set_out, .watchdog_counter_clr_out, .postscaler_clr_out, .timeout_flag_n_set_out,
  .powerdown_flag_n_set_out, .busy_out);

// *** tb.sv ***
// self-checking bench for the branch, call and clear execution block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_in = 1'b0, sys_rst_in = 1'b1, instr_valid_in = 1'b0;
  logic [15:0] instr_word_in = 16'h0000, second_word_in = 16'hF000;
  logic [20:0] pc_incr_in = 21'h000000;
  logic [7:0]  status_in = 8'h00, working_in = 8'h3C, bank_select_register_in = 8'h05;
  wire  [20:0] pc_out, top_of_return_stack_out;
  wire  [7:0]  working_shadow_out, status_shadow_out, bank_select_shadow_out, clr_addr_out, clr_data_out;
  wire         pc_write_out, push_out, clr_write_out, clr_bank_out, zero_set_out, watchdog_counter_clr_out;
  wire         postscaler_clr_out, timeout_flag_n_set_out, powerdown_flag_n_set_out, busy_out;
  wire  [3:0]  phase_out;
  logic [3:0]  n_pw, n_ps, n_cl, n_wd, n_busy;
  logic [20:0] got_pc, got_ret, got_lvl;
  logic [16:0] got_clr;
  int          miscompares = 0, n_compared = 0;
  bcc_exec i_bcc_exec (.core_clk_in, .sys_rst_in, .instr_word_in, .second_word_in, .instr_valid_in, .pc_incr_in,
    .status_in, .working_in, .bank_select_register_in, .pc_out, .pc_write_out, .push_out, .top_of_return_stack_out,
    .working_shadow_out, .status_shadow_out, .bank_select_shadow_out, .clr_write_out, .clr_addr_out, .clr_bank_out,
    .clr_data_out, .zero_set_out, .watchdog_counter_clr_out, .postscaler_clr_out, .timeout_flag_n_set_out,
    .powerdown_flag_n_set_out, .busy_out, .phase_out);
  always #4 core_clk_in = ~core_clk_in;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one instruction slot; the following slot idles so strobes of neighbours never overlap
  task automatic run(input logic [15:0] w, w2, input logic [7:0] st, input logic [20:0] pc, input logic v, int len);
    {n_pw, n_ps, n_cl, n_wd, n_busy} = 20'h00000;
    instr_word_in <= w;
    second_word_in <= w2;
    status_in <= st;
    pc_incr_in <= pc;
    instr_valid_in <= v;
    @(posedge core_clk_in);
    instr_valid_in <= 1'b0;
    repeat (len - 1)
    begin
      @(negedge core_clk_in);
      n_pw += pc_write_out;
      n_ps += push_out;
      n_cl += clr_write_out + zero_set_out;
      n_wd += watchdog_counter_clr_out + postscaler_clr_out + timeout_flag_n_set_out + powerdown_flag_n_set_out;
      n_busy += busy_out;
      got_lvl = pc_out;
      if (pc_write_out) got_pc = pc_out;
      if (push_out) got_ret = top_of_return_stack_out;
      if (clr_write_out) got_clr = {clr_bank_out, clr_addr_out, clr_data_out};
    end
    @(posedge core_clk_in);
  endtask
  task automatic t_branch;
    run(16'hE080, 16'hF000, 8'h04, 21'h001000, 1'b1, 12);
    chk({n_pw, n_ps, n_cl, n_wd, n_busy}, 20'h10004);
    chk(got_pc, 21'h000F00);
    run(16'hE080, 16'hF000, 8'h08, 21'h001000, 1'b1, 8);
    chk({n_pw, n_ps, n_cl, n_wd, n_busy}, 20'h00000);
    chk(got_lvl, 21'h001000);
    run(16'hE47F, 16'hF000, 8'h08, 21'h001000, 1'b1, 12);
    chk({n_pw, n_ps, n_cl, n_wd, n_busy}, 20'h10004);
    chk(got_pc, 21'h0010FE);
    run(16'hE47F, 16'hF000, 8'h04, 21'h001000, 1'b1, 8);
    chk({n_pw, n_ps, n_cl, n_wd, n_busy}, 20'h00000);
    run(16'hE001, 16'hF000, 8'h04, 21'h001000, 1'b0, 8);
    chk({n_pw, n_ps, n_cl, n_wd, n_busy}, 20'h00000);
    $display("branch test done");
  endtask
  task automatic t_call;
    run(16'hEDDE, 16'hFABC, 8'h5A, 21'h000200, 1'b1, 12);
    chk({n_pw, n_ps, n_cl, n_wd, n_busy}, 20'h11004);
    chk(got_pc, 21'h1579BC);
    chk(got_ret, 21'h000202);
    chk({working_shadow_out, status_shadow_out, bank_select_shadow_out}, 24'h3C5A05);
    working_in <= 8'hC3;
    bank_select_register_in <= 8'h0A;
    run(16'hEC12, 16'hF345, 8'h11, 21'h000400, 1'b1, 12);
    chk(got_pc, 21'h068A24);
    chk(got_ret, 21'h000402);
    chk({working_shadow_out, status_shadow_out, bank_select_shadow_out}, 24'h3C5A05);
    $display("call test done");
  endtask
  task automatic t_clear;
    run(16'h6BA5, 16'hF000, 8'h00, 21'h000010, 1'b1, 8);
    chk({n_pw, n_ps, n_cl, n_wd, n_busy}, 20'h00200);
    chk(got_clr, 17'h1A500);
    run(16'h6A5A, 16'hF000, 8'h00, 21'h000010, 1'b1, 8);
    chk(got_clr, 17'h05A00);
    run(16'h0004, 16'hF000, 8'h00, 21'h000010, 1'b1, 8);
    chk({n_pw, n_ps, n_cl, n_wd, n_busy}, 20'h00040);
    $display("clear test done");
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (n_compared > 0 && miscompares == 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk_in);
    chk({pc_out, working_shadow_out, phase_out}, 33'h000000001);
    sys_rst_in <= 1'b0;
    t_branch;
    t_call;
    t_clear;
    stop_test;
  end
endmodule
